// ### verilog/sld_pkg.sv
// package: constants and carriers for the serial link datapath
package sld_pkg;
  localparam logic [7:0] SLD_CTRL_OFS = 8'h00;
  localparam logic [7:0] SLD_STATUS_OFS = 8'h04;
  localparam logic [7:0] SLD_RXDATA_OFS = 8'h08;
  localparam logic [7:0] SLD_LFCFG_OFS = 8'h0c;
  localparam int SLD_FIFO_DEPTH = 256;
  localparam int SLD_FIFO_AW = 8;
  localparam logic [3:0] SLD_BITS_STD = 4'ha;
  localparam logic [3:0] SLD_BITS_RAW12 = 4'hc;
  localparam logic [7:0] SLD_IDLE_DATA = 8'hbc;
  localparam logic [6:0] SLD_CTRL_RST = 7'h07;
  localparam logic [23:0] SLD_LFCFG_RST = 24'h10_40_02;
  localparam int SLD_ST_CODE_ERR = 3;
  localparam logic [6:0] SLD_COMMA_NEG = 7'h1f;
  localparam logic [6:0] SLD_COMMA_POS = 7'h60;
  localparam logic [5:0] SLD_K28_NEG = 6'h0f;
  localparam logic [5:0] SLD_K28_POS = 6'h30;
  localparam logic [3:0] SLD_ALT7 = 4'h7;
  // 5b/6b and 3b/4b codes for negative running disparity, bit a / f at msb
  localparam logic [5:0] SLD_ENC6 [32] = '{
    6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
    6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
  localparam logic [3:0] SLD_ENC4 [8] = '{4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, 4'he};

  typedef struct packed {
    logic [1:0] ref_ratio;
    logic rx_sel_b;
    logic cascade;
    logic fifo_en;
    logic encoder_bypass_n;
    logic char_size_select;
  } sld_ctrl_t;

  typedef struct packed {
    logic [7:0] run_limit;
    logic [7:0] period_max;
    logic [7:0] period_min;
  } sld_lfcfg_t;

  typedef struct packed {
    logic [8:0] fifo_count;
    logic frame_locked;
    logic code_err;
    logic tx_empty;
    logic tx_full;
    logic link_fault_n;
  } sld_status_t;

  typedef struct packed {
    logic en;
    logic sc_d;
    logic [11:0] data;
  } sld_tx_host_t;

  typedef struct packed {
    logic valid;
    logic k;
    logic err;
    logic [11:0] data;
  } sld_rx_char_t;

  typedef enum logic [1:0] {
    SLD_FRM_HUNT = 2'b01,
    SLD_FRM_LOCK = 2'b10
  } sld_frm_t;
endpackage

// ### verilog/sld_serial_link_datapath.sv
// serial link datapath: host transmit path, line coder, receive framer, link monitor
`timescale 1ns/1ps
// Contract
// - link_fault_n is active low and changes only on recovered clock edges or when carrier detect goes low
// - link fault asserts when the selected serial input cannot be recovered
// - low transition density or low amplitude counts as a link fault
// - incoming stream frequency outside allowed range counts as a link fault
// - carrier detect low forces link_fault_n low
// - asynchronous mode uses host clock and a 256 character transmit fifo
// - asynchronous host writes accepted at any rate up to 50 MHz
// - synchronous mode samples the host interface on reference clock edges
// - synchronous host writes once per character; reference is 1, 2 or 4x
// - transmit host bus carries 8, 10 or 12 bit characters
// - size select and bypass pick encoded 8 (size select ignored), raw 10, raw 12
// - both clocking modes offer utopia and cascade timing models
// - utopia model uses active low enable and flags
// - cascade model behaves like a synchronous fifo, active high
// - transmit characters pass an 8b/10b encoder unless bypassed
// - serializer sends ten bits per character, 2.5, 5 or 10 per reference
// - raw 12 bit mode sends twelve bits, 3, 6 or 12 per reference
// - receive data comes from one of two serial inputs
// - the input selector picks which stream feeds recovery
// - framer moves character boundaries onto the transmitted ones
// - 10b/8b decoder restores characters unless bypassed
module sld_serial_link_datapath (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // host transmit interface
  input wire logic host_tx_clock,
  input wire sld_pkg::sld_tx_host_t tx_host,
  output logic tx_full_flag,
  output logic tx_empty_flag,
  // serial transmit
  input wire logic reference_clock,
  output logic tx_serial_bit,
  output logic tx_bit_strobe,
  // serial receive and link status
  input wire logic serial_in_a,
  input wire logic serial_in_b,
  input wire logic recovered_rx_clock,
  input wire logic amplitude_ok_a,
  input wire logic amplitude_ok_b,
  input wire logic carrier_detect_in,
  output logic link_fault_n,
  output sld_pkg::sld_rx_char_t rx_char
);
  import sld_pkg::*;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  function automatic logic [10:0] enc8b10b(input logic [7:0] d, input logic kc, input logic rd);
    logic [5:0] c6;
    logic [3:0] c4;
    logic [9:0] w;
    logic [4:0] x;
    logic k28;
    logic r;
    logic a7;
    x = d[4:0];
    k28 = kc && x == 5'd28;
    c6 = k28 ? SLD_K28_NEG : SLD_ENC6[x];
    if (rd && ($countones(c6) != 3 || x == 5'd7)) c6 = ~c6;
    r = rd ^ ($countones(c6) != 3);
    a7 = (d[7:5] == 3'd7) && (k28 || (!r && (x == 5'd17 || x == 5'd18 || x == 5'd20)) ||
         (r && (x == 5'd11 || x == 5'd13 || x == 5'd14)));
    c4 = a7 ? SLD_ALT7 : SLD_ENC4[d[7:5]];
    // K28 control characters flip their balanced tail the other way round
    if (($countones(c4) != 2 || d[7:5] == 3'd3) ? r : (k28 && !r)) c4 = ~c4;
    w = {<<{c6, c4}};
    return {r ^ ($countones(c4) != 2), w};
  endfunction

  // input is msb first (bit a at 9); result {err, k, hgf, edcba}
  function automatic logic [9:0] dec10b8b(input logic [9:0] w);
    logic [5:0] six;
    logic [3:0] four;
    logic [4:0] x;
    logic [2:0] y;
    logic hx;
    logic hy;
    logic k;
    six = w[9:4];
    x = '0;
    y = '0;
    hx = 1'b0;
    hy = 1'b0;
    k = (six == SLD_K28_NEG) || (six == SLD_K28_POS);
    four = (six == SLD_K28_POS) ? ~w[3:0] : w[3:0];
    for (int i = 0; i < 32; i++) begin
      if (SLD_ENC6[i] == six || (($countones(SLD_ENC6[i]) != 3 || i == 7) && ~SLD_ENC6[i] == six)) begin
        x = 5'(i);
        hx = 1'b1;
      end
    end
    if (k) begin
      x = 5'd28;
      hx = 1'b1;
    end
    for (int j = 0; j < 8; j++) begin
      if (SLD_ENC4[j] == four || (($countones(SLD_ENC4[j]) != 2 || j == 3) && ~SLD_ENC4[j] == four)) begin
        y = 3'(j);
        hy = 1'b1;
      end
    end
    if (four == SLD_ALT7 || four == ~SLD_ALT7) begin
      y = 3'd7;
      hy = 1'b1;
    end
    return {!(hx && hy), k, y, x};
  endfunction

  // every host and serial pin is foreign to pclk: clocks are sampled and edge detected
  logic [21:0] sync1_q;
  logic [21:0] sync2_q;
  logic [2:0] clk_prev_q;
  logic htx_s, ref_s, in_a_s, in_b_s, rxc_s, amp_a_s, amp_b_s, carrier_s;
  sld_tx_host_t host_s;
  logic htx_edge, ref_edge, rx_edge;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      clk_prev_q <= '0;
    end else begin
      sync1_q <= {host_tx_clock, tx_host, reference_clock, serial_in_a, serial_in_b,
                  recovered_rx_clock, amplitude_ok_a, amplitude_ok_b, carrier_detect_in};
      sync2_q <= sync1_q;
      clk_prev_q <= {htx_s, ref_s, rxc_s};
    end
  end
  assign {htx_s, host_s, ref_s, in_a_s, in_b_s, rxc_s, amp_a_s, amp_b_s, carrier_s} = sync2_q;
  assign htx_edge = htx_s && !clk_prev_q[2];
  assign ref_edge = ref_s && !clk_prev_q[1];
  assign rx_edge = rxc_s && !clk_prev_q[0];

  // register bus: zero wait states, unmapped offsets answer with pslverr
  sld_ctrl_t ctrl_q;
  sld_lfcfg_t lfcfg_q;
  sld_status_t status;
  sld_rx_char_t rx_char_q;
  logic [31:0] prdata_q;
  logic apb_setup, apb_wr, apb_rd, addr_ok;
  logic code_err_q, rx_fresh_q, rx_pop;
  logic encoded, raw12;
  logic [3:0] nbits;

  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && penable && !pwrite;
  assign addr_ok = paddr inside {SLD_CTRL_OFS, SLD_STATUS_OFS, SLD_RXDATA_OFS, SLD_LFCFG_OFS};
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata = prdata_q;
  // a character landing at the setup edge was not in prdata, so it is kept
  assign rx_pop = apb_rd && paddr == SLD_RXDATA_OFS && !rx_fresh_q;

  assign encoded = ctrl_q.encoder_bypass_n;
  assign raw12 = !ctrl_q.char_size_select && !ctrl_q.encoder_bypass_n;
  assign nbits = raw12 ? SLD_BITS_RAW12 : SLD_BITS_STD;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= sld_ctrl_t'(SLD_CTRL_RST);
      lfcfg_q <= sld_lfcfg_t'(SLD_LFCFG_RST);
    end else if (apb_wr) begin
      if (paddr == SLD_CTRL_OFS) ctrl_q <= sld_ctrl_t'(pwdata[6:0]);
      if (paddr == SLD_LFCFG_OFS) lfcfg_q <= sld_lfcfg_t'(pwdata[23:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (apb_setup) begin
      case (paddr)
        SLD_CTRL_OFS: prdata_q <= {25'h0, ctrl_q};
        SLD_STATUS_OFS: prdata_q <= {18'h0, status};
        SLD_RXDATA_OFS: prdata_q <= {17'h0, rx_char_q};
        SLD_LFCFG_OFS: prdata_q <= {8'h0, lfcfg_q};
        default: prdata_q <= '0;
      endcase
    end
  end

  // transmit fifo and synchronous pipeline register
  logic [12:0] fifo_mem [SLD_FIFO_DEPTH];
  logic [SLD_FIFO_AW-1:0] wr_ptr_q, rd_ptr_q;
  logic [8:0] fifo_cnt_q;
  logic fifo_full, fifo_empty, fifo_wr, fifo_rd, host_en_act, char_tick;
  logic [1:0] ref_cnt_q, ratio_max;
  logic [12:0] pipe_q, tx_src, idle_char;

  assign fifo_full = fifo_cnt_q == 9'(SLD_FIFO_DEPTH);
  assign fifo_empty = fifo_cnt_q == 9'h0;
  assign host_en_act = ctrl_q.cascade ? host_s.en : !host_s.en;
  assign tx_full_flag = ctrl_q.cascade ? fifo_full : !fifo_full;
  assign tx_empty_flag = ctrl_q.cascade ? fifo_empty : !fifo_empty;
  assign fifo_wr = ctrl_q.fifo_en && htx_edge && host_en_act && !fifo_full;
  assign fifo_rd = ctrl_q.fifo_en && char_tick && !fifo_empty;
  assign idle_char = {1'b1, 4'h0, SLD_IDLE_DATA};

  always_ff @(posedge pclk) begin
    if (fifo_wr) fifo_mem[wr_ptr_q] <= {host_s.sc_d, host_s.data};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      fifo_cnt_q <= '0;
    end else begin
      if (fifo_wr) wr_ptr_q <= wr_ptr_q + 8'h1;
      if (fifo_rd) rd_ptr_q <= rd_ptr_q + 8'h1;
      if (fifo_wr && !fifo_rd) fifo_cnt_q <= fifo_cnt_q + 9'h1;
      else if (fifo_rd && !fifo_wr) fifo_cnt_q <= fifo_cnt_q - 9'h1;
    end
  end

  always_comb begin
    case (ctrl_q.ref_ratio)
      2'd0: ratio_max = 2'd0;
      2'd1: ratio_max = 2'd1;
      default: ratio_max = 2'd3;
    endcase
  end
  assign char_tick = ref_edge && ref_cnt_q == ratio_max;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_cnt_q <= '0;
    end else if (ref_edge) begin
      ref_cnt_q <= char_tick ? 2'd0 : ref_cnt_q + 2'd1;
    end
  end

  // synchronous mode: host bus taken once per character on a reference edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pipe_q <= {1'b1, 4'h0, SLD_IDLE_DATA};
    end else if (!ctrl_q.fifo_en && char_tick) begin
      pipe_q <= host_en_act ? {host_s.sc_d, host_s.data} : idle_char;
    end
  end

  assign tx_src = ctrl_q.fifo_en ? (fifo_empty ? idle_char : fifo_mem[rd_ptr_q]) : pipe_q;

  // encoder and serializer, first bit out is bit 0
  logic [10:0] enc;
  logic [11:0] code12, tx_sh_q;
  logic [3:0] tx_left_q;
  logic tx_rd_q, tx_bit_q, tx_strobe_q;

  assign enc = enc8b10b(tx_src[7:0], tx_src[12], tx_rd_q);
  always_comb begin
    if (raw12) code12 = tx_src[11:0];
    else if (encoded) code12 = {2'b00, enc[9:0]};
    else code12 = {2'b00, tx_src[9:0]};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_sh_q <= '0;
      tx_left_q <= '0;
      tx_rd_q <= 1'b0;
      tx_bit_q <= 1'b0;
      tx_strobe_q <= 1'b0;
    end else begin
      tx_strobe_q <= tx_left_q != 4'h0;
      if (tx_left_q != 4'h0) tx_bit_q <= tx_sh_q[0];
      if (char_tick) begin
        tx_sh_q <= code12;
        tx_left_q <= nbits;
        if (encoded) tx_rd_q <= enc[10];
      end else if (tx_left_q != 4'h0) begin
        tx_sh_q <= {1'b0, tx_sh_q[11:1]};
        tx_left_q <= tx_left_q - 4'h1;
      end
    end
  end
  assign tx_serial_bit = tx_bit_q;
  assign tx_bit_strobe = tx_strobe_q;

  // link monitor
  logic sel_bit, amp_sel, last_bit_q, link_fault_n_q, freq_bad, dens_bad;
  logic [8:0] period_q;
  logic [7:0] run_q;

  assign sel_bit = ctrl_q.rx_sel_b ? in_b_s : in_a_s;
  assign amp_sel = ctrl_q.rx_sel_b ? amp_b_s : amp_a_s;
  assign freq_bad = period_q < {1'b0, lfcfg_q.period_min} || period_q > {1'b0, lfcfg_q.period_max};
  assign dens_bad = run_q >= lfcfg_q.run_limit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_q <= '0;
      run_q <= '0;
      last_bit_q <= 1'b0;
    end else begin
      if (rx_edge) period_q <= 9'h1;
      else if (period_q != 9'h1ff) period_q <= period_q + 9'h1;
      if (rx_edge) begin
        last_bit_q <= sel_bit;
        if (sel_bit != last_bit_q) run_q <= '0;
        else if (run_q != 8'hff) run_q <= run_q + 8'h1;
      end
    end
  end

  // a lost carrier acts at once since the recovered clock may stop with it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_fault_n_q <= 1'b0;
    end else if (!carrier_s) begin
      link_fault_n_q <= 1'b0;
    end else if (rx_edge) begin
      link_fault_n_q <= !(freq_bad || dens_bad || !amp_sel);
    end
  end
  assign link_fault_n = link_fault_n_q;

  // deserializer, framer and decoder
  sld_frm_t frm_q;
  logic [11:0] rx_sh_q, rx_sh_d;
  logic [9:0] rx_w, rx_dec;
  logic [3:0] rx_cnt_q;
  logic comma, rx_emit;

  assign rx_sh_d = {sel_bit, rx_sh_q[11:1]};
  assign rx_w = {<<{rx_sh_d[11:2]}};
  assign rx_dec = dec10b8b(rx_w);
  assign comma = encoded && (rx_w[9:3] == SLD_COMMA_NEG || rx_w[9:3] == SLD_COMMA_POS);
  assign rx_emit = rx_edge && ((frm_q == SLD_FRM_HUNT && comma) ||
                   (frm_q == SLD_FRM_LOCK && (comma || rx_cnt_q == nbits - 4'h1)));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frm_q <= SLD_FRM_HUNT;
      rx_cnt_q <= '0;
      rx_sh_q <= '0;
    end else begin
      if (rx_edge) begin
        rx_sh_q <= rx_sh_d;
        unique case (frm_q)
          SLD_FRM_HUNT: begin
            if (comma || !encoded) begin
              frm_q <= SLD_FRM_LOCK;
              rx_cnt_q <= '0;
            end
          end
          SLD_FRM_LOCK: begin
            if (comma || rx_cnt_q == nbits - 4'h1) rx_cnt_q <= '0;
            else rx_cnt_q <= rx_cnt_q + 4'h1;
          end
          default: frm_q <= SLD_FRM_HUNT;
        endcase
      end
      if (!link_fault_n_q && encoded) frm_q <= SLD_FRM_HUNT;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_char_q <= '0;
      rx_fresh_q <= 1'b0;
      code_err_q <= 1'b0;
    end else begin
      rx_fresh_q <= rx_emit;
      if (rx_emit) begin
        rx_char_q.valid <= 1'b1;
        rx_char_q.k <= encoded && rx_dec[8];
        rx_char_q.err <= encoded && rx_dec[9];
        if (encoded) rx_char_q.data <= {4'h0, rx_dec[7:0]};
        else if (raw12) rx_char_q.data <= rx_sh_d;
        else rx_char_q.data <= {2'b00, rx_sh_d[11:2]};
      end else if (rx_pop) begin
        rx_char_q.valid <= 1'b0;
      end
      if (rx_emit && encoded && rx_dec[9]) code_err_q <= 1'b1;
      else if (apb_wr && paddr == SLD_STATUS_OFS && pwdata[SLD_ST_CODE_ERR]) code_err_q <= 1'b0;
    end
  end
  assign rx_char = rx_char_q;

  assign status = '{fifo_count: fifo_cnt_q, frame_locked: frm_q == SLD_FRM_LOCK, code_err: code_err_q,
                    tx_empty: fifo_empty, tx_full: fifo_full, link_fault_n: link_fault_n_q};

  property p_lf_carrier;
    !carrier_s |=> !link_fault_n;
  endproperty
  a_lf_carrier: assert property (p_lf_carrier) else $error("carrier loss left link fault high");

  property p_lf_step;
    !$stable(link_fault_n) |-> $past(rx_edge) || $past(!carrier_s);
  endproperty
  a_lf_step: assert property (p_lf_step) else $error("link fault moved off a recovered edge");

  property p_lf_cause;
    rx_edge && carrier_s && (!amp_sel || dens_bad) |=> !link_fault_n;
  endproperty
  a_lf_cause: assert property (p_lf_cause) else $error("bad input not flagged");

  property p_lf_freq;
    rx_edge && carrier_s && freq_bad |=> !link_fault_n;
  endproperty
  a_lf_freq: assert property (p_lf_freq) else $error("frequency fault not flagged");

  property p_lf_good;
    rx_edge && carrier_s && amp_sel && !dens_bad && !freq_bad ##1 carrier_s |-> link_fault_n;
  endproperty
  a_lf_good: assert property (p_lf_good) else $error("healthy link flagged as fault");

  property p_fifo_fill;
    fifo_wr && !fifo_rd |=> fifo_cnt_q == $past(fifo_cnt_q) + 9'h1 && !fifo_empty;
  endproperty
  a_fifo_fill: assert property (p_fifo_fill) else $error("fifo write not counted");

  property p_ser_burst;
    char_tick |-> ##2 tx_bit_strobe [*8];
  endproperty
  a_ser_burst: assert property (p_ser_burst) else $error("serializer burst too short");

  property p_ser_raw12;
    char_tick && raw12 |-> ##12 tx_left_q == 4'h1 ##1 tx_left_q == 4'h0;
  endproperty
  a_ser_raw12: assert property (p_ser_raw12) else $error("raw twelve bit length wrong");

  property p_rx_gate;
    rx_emit && encoded |-> frm_q == SLD_FRM_LOCK || comma;
  endproperty
  a_rx_gate: assert property (p_rx_gate) else $error("character shown before lock");

  property p_comma;
    rx_edge && comma && link_fault_n_q |=> frm_q == SLD_FRM_LOCK && rx_cnt_q == 4'h0 && rx_char_q.valid;
  endproperty
  a_comma: assert property (p_comma) else $error("comma did not set boundary");
endmodule

// ### tb/sld_host_model.sv
// host transmit writer model for the serial link datapath
`timescale 1ns/1ps
module sld_host_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control from the bench
  input wire logic go,
  input wire logic cascade,
  input wire logic [11:0] wdata,
  // host transmit pins
  output logic host_tx_clock,
  output sld_pkg::sld_tx_host_t tx_host,
  output logic [15:0] wr_cnt
);
  import sld_pkg::*;
  logic [2:0] ph_q;
  // eight pclk per write keeps the host far below 50 mhz; go is looked at in phase 1 only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_q <= 3'h1;
      host_tx_clock <= 1'b0;
      tx_host <= '{en: 1'b1, sc_d: 1'b0, data: 12'h000};
      wr_cnt <= 16'h0000;
    end else begin
      ph_q <= (ph_q == 3'h1 && !go) ? 3'h1 : ph_q + 3'h1;
      case (ph_q)
        3'h2: tx_host <= '{en: cascade, sc_d: 1'b0, data: wdata};
        3'h4: host_tx_clock <= 1'b1;
        3'h6: host_tx_clock <= 1'b0;
        3'h7: begin
          // released bus shows inverted data so a stale value never passes
          tx_host <= '{en: ~cascade, sc_d: 1'b1, data: ~tx_host.data};
          wr_cnt <= wr_cnt + 16'h0001;
        end
        default: ;
      endcase
    end
  end
endmodule

// ### tb/sld_serial_link_datapath_bench.sv
// self-checking bench for the serial link datapath
`timescale 1ns/1ps
module sld_serial_link_datapath_bench;
  import sld_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, host_tx_clock, tx_full_flag, tx_empty_flag, tx_serial_bit, tx_bit_strobe, link_fault_n;
  logic reference_clock = 1'b0;
  logic ref_run = 1'b0;
  logic serial_bit = 1'b0;
  logic recovered_rx_clock = 1'b0;
  logic amp_a = 1'b1;
  logic amp_b = 1'b1;
  logic carrier_detect_in = 1'b1;
  logic go = 1'b0;
  logic casc = 1'b0;
  logic [11:0] wdata = 12'h000;
  logic [15:0] wr_cnt;
  sld_tx_host_t tx_host;
  sld_rx_char_t rx_char;
  logic [11:0] acc = 12'h000;
  logic [11:0] words[$];
  int bitn = 0;
  int nbits = 10;
  int stb_total = 0;
  int ref_div = 0;
  int cyc = 0;
  int error_cnt = 0;
  int checks = 0;

  always #5 pclk = ~pclk;

  sld_serial_link_datapath i_sld_serial_link_datapath (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .host_tx_clock(host_tx_clock),
    .tx_host(tx_host), .tx_full_flag(tx_full_flag), .tx_empty_flag(tx_empty_flag),
    .reference_clock(reference_clock), .tx_serial_bit(tx_serial_bit), .tx_bit_strobe(tx_bit_strobe),
    .serial_in_a(serial_bit), .serial_in_b(serial_bit), .recovered_rx_clock(recovered_rx_clock),
    .amplitude_ok_a(amp_a), .amplitude_ok_b(amp_b), .carrier_detect_in(carrier_detect_in),
    .link_fault_n(link_fault_n), .rx_char(rx_char));

  sld_host_model i_sld_host_model (
    .pclk(pclk), .presetn(presetn), .go(go), .cascade(casc), .wdata(wdata),
    .host_tx_clock(host_tx_clock), .tx_host(tx_host), .wr_cnt(wr_cnt));

  // reference period of 40 pclk; held still while the fifo is filled
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (ref_run) ref_div <= (ref_div == 19) ? 0 : ref_div + 1;
    if (ref_run && ref_div == 19) reference_clock <= ~reference_clock;
    if (cyc == 40000) begin
      error_cnt = error_cnt + 1;
      tally_and_finish();
    end
  end

  // serial monitor: a character is one unbroken burst of strobes, bit 0 first
  always @(posedge pclk) begin
    if (tx_bit_strobe === 1'b1) begin
      acc[bitn] = tx_serial_bit;
      stb_total++;
      if (bitn == nbits - 1) begin
        words.push_back(acc);
        acc = 12'h000;
        bitn = 0;
      end else begin
        bitn++;
      end
    end else begin
      bitn = 0;
    end
  end

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0, rd, err);
    chk_word(what, exp, rd & mask);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, d, rd, err);
  endtask

  // ten pclk per bit; the recovered clock stands still between words
  task automatic send(input logic [9:0] w);
    for (int i = 0; i < 10; i++) begin
      @(posedge pclk);
      serial_bit <= w[i];
      repeat (4) @(posedge pclk);
      recovered_rx_clock <= 1'b1;
      repeat (5) @(posedge pclk);
      recovered_rx_clock <= 1'b0;
    end
    serial_bit <= ~w[9];
  endtask

  task automatic lf(input string what, input logic exp);
    send(10'h17c);
    send(10'h283);
    chk_bit(what, exp, link_fault_n);
  endtask

  task automatic wait_cnt(input int n);
    int t = 0;
    while (int'(wr_cnt) < n && t < 4000) begin
      @(negedge pclk);
      t++;
    end
    @(posedge pclk);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    logic [31:0] rd;
    logic err;
    int n2, n15, nxt, s0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("ctrl reset", SLD_CTRL_OFS, 32'hffffffff, 32'h00000007);
    rd_chk("lfcfg reset", SLD_LFCFG_OFS, 32'hffffffff, 32'h00104002);
    apb(1'b0, 8'h10, 32'h0, rd, err);
    chk_bit("unmapped slverr", 1'b1, err);
    chk_bit("empty utopia", 1'b0, tx_empty_flag);
    chk_bit("full utopia", 1'b1, tx_full_flag);
    $display("test reset done");
    send(10'h155);
    send(10'h155);
    rd_chk("rx before comma", SLD_RXDATA_OFS, 32'h00004000, 32'h0);
    lf("lf clean stream", 1'b1);
    lf("lf clean stream", 1'b1);
    rd_chk("rx comma", SLD_RXDATA_OFS, 32'h000070ff, 32'h000060bc);
    rd_chk("frame locked", SLD_STATUS_OFS, 32'h00000011, 32'h00000011);
    $display("test framing done");
    amp_a <= 1'b0;
    repeat (20) @(posedge pclk);
    chk_bit("lf held without rx clock", 1'b1, link_fault_n);
    lf("lf amplitude", 1'b0);
    amp_a <= 1'b1;
    amp_b <= 1'b0;
    lf("lf unselected input", 1'b1);
    wr(SLD_CTRL_OFS, 32'h00000017);
    lf("lf selected input", 1'b0);
    amp_b <= 1'b1;
    lf("lf input b good", 1'b1);
    wr(SLD_CTRL_OFS, 32'h00000007);
    send(10'h000);
    send(10'h000);
    chk_bit("lf density", 1'b0, link_fault_n);
    lf("lf recovered", 1'b1);
    wr(SLD_LFCFG_OFS, 32'h00100402);
    lf("lf slow stream", 1'b0);
    wr(SLD_LFCFG_OFS, 32'h0010400c);
    lf("lf fast stream", 1'b0);
    wr(SLD_LFCFG_OFS, 32'h00104002);
    carrier_detect_in <= 1'b0;
    repeat (6) @(posedge pclk);
    chk_bit("lf carrier", 1'b0, link_fault_n);
    carrier_detect_in <= 1'b1;
    lf("lf carrier back", 1'b1);
    $display("test link fault done");
    casc <= 1'b1;
    wr(SLD_CTRL_OFS, 32'h0000000d);
    @(posedge pclk);
    chk_bit("empty cascade", 1'b1, tx_empty_flag);
    wdata <= 12'h2a5;
    go <= 1'b1;
    wait_cnt(1);
    wdata <= 12'h15a;
    wait_cnt(260);
    go <= 1'b0;
    rd_chk("fifo full", SLD_STATUS_OFS, 32'h00003fe6, 32'h00002002);
    chk_bit("full cascade", 1'b1, tx_full_flag);
    words.delete();
    ref_run <= 1'b1;
    s0 = 0;
    while (tx_empty_flag !== 1'b1 && s0 < 12000) begin
      @(posedge pclk);
      s0++;
    end
    repeat (100) @(posedge pclk);
    n2 = 0;
    n15 = 0;
    nxt = 0;
    foreach (words[i]) begin
      if (words[i] === 12'h2a5 && i + 1 < words.size()) nxt = words[i + 1];
      n2 += (words[i] === 12'h2a5);
      n15 += (words[i] === 12'h15a);
    end
    chk_word("raw10 first char", 32'h1, n2);
    chk_word("raw10 order", 32'h15a, nxt);
    chk_word("fifo depth", 32'hff, n15);
    for (int r = 0; r < 2; r++) begin
      wr(SLD_CTRL_OFS, r ? 32'h0000004d : 32'h0000000d);
      s0 = stb_total;
      repeat (640) @(posedge pclk);
      n2 = stb_total - s0;
      chk_bit("strobe rate", 1'b1, n2 >= (r ? 30 : 150) && n2 <= (r ? 50 : 170));
    end
    $display("test transmit done");
    wr(SLD_CTRL_OFS, 32'h0000000c);
    nbits = 12;
    words.delete();
    wdata <= 12'ha5c;
    go <= 1'b1;
    wait_cnt(int'(wr_cnt) + 1);
    go <= 1'b0;
    repeat (200) @(posedge pclk);
    n2 = 0;
    foreach (words[i]) n2 += (words[i] === 12'ha5c);
    chk_word("raw12 char", 32'h1, n2);
    $display("test raw12 done");
    tally_and_finish();
  end
endmodule
